// File: core/posc_pkg.sv
// Purpose: constants for the operating state controller
// Assumes: 16-bit management registers, 40 MHz core clock
// Notes: addresses are management register indices
package posc_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam logic [15:0] ADDR_RESET_CTRL = 16'h001f;
   localparam logic [15:0] ADDR_PWR_MODE = 16'h018b;
   localparam logic [15:0] ADDR_STATE_CMD = 16'h018c;
   localparam logic [15:0] ADDR_SLEEP_A = 16'h042f;
   localparam logic [15:0] ADDR_SLEEP_B = 16'h041e;
   localparam logic [15:0] SLEEP_A_VAL = 16'h0007;
   localparam logic [15:0] SLEEP_B_VAL = 16'h0100;
   localparam logic [15:0] CMD_TO_NORMAL = 16'h0001;
   localparam logic [15:0] CMD_TO_STANDBY = 16'h0010;
   localparam int unsigned BIT_HW_RESET = 15;
   localparam int unsigned BIT_AUTONOMOUS = 6;
   localparam int unsigned BIT_SLEEP_EN = 7;
   localparam int unsigned BIT_REMOTE_SLEEP = 8;
   localparam logic [15:0] PWR_MODE_RST = 16'h0000;
   localparam logic [15:0] STATE_CMD_RST = 16'h0000;
   // wake sequence minimum, in microseconds
   localparam int unsigned WAKE_SEQ_US = 1250;
   localparam int unsigned WAKE_SEQ_CYC = (WAKE_SEQ_US * (CLK_HZ / 1_000_000));
   // reset pulse length held internally after a register reset
   localparam int unsigned RST_HOLD_CYC = 4;
   typedef enum logic [2:0] {
      ST_POWER_DOWN,
      ST_RESET,
      ST_STANDBY,
      ST_NORMAL,
      ST_SLEEP
   } posc_state_e;
endpackage

// File: core/posc_wake_timer.sv
// Purpose: qualifies a remote wake pattern held long enough
// Assumes: pattern detect level synchronous to the core clock
// Notes: count restarts whenever the pattern drops
`timescale 1ns/10ps
module posc_wake_timer
   import posc_pkg::*;
#(
   parameter int unsigned CYCLES = WAKE_SEQ_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_pattern,
   output logic o_qualified
);
   localparam int unsigned W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic qual_q;
   logic qual_d;

   if (CYCLES < 1) begin : g_bad_cycles
      $error("wake timer needs at least one cycle");
   end

   always_comb begin
      cnt_d = cnt_q;
      qual_d = 1'b0;
      if (!i_pattern) begin
         cnt_d = '0;
      end else if (cnt_q == W'(CYCLES)) begin
         qual_d = 1'b1;
      end else begin
         cnt_d = cnt_q + W'(1);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
         qual_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         qual_q <= qual_d;
      end
   end

   assign o_qualified = qual_q;
endmodule // posc_wake_timer

// File: core/posc_ctrl.sv
// Purpose: operating state controller for a single-pair ethernet transceiver
// Assumes: management writes arrive as one-cycle strobes with index and data
// Notes: strap pins are sampled after pin reset release only
//
// Behaviour
// R1 - straps re-latch on pin reset only
// R2 - managed strap enters standby after reset
// R3 - standby keeps pcs and pma disabled
// R4 - standby keeps management access and registers
// R5 - autonomous strap goes normal by itself
// R6 - command 0x001 moves standby to normal
// R7 - power mode bit 6 selects autonomous
// R8 - command 0x0010 returns normal to standby
// R9 - sleep: only energy detect, no management
// R10 - registers return to defaults after sleep
// R11 - host master local sleep write sequence
// R12 - host slave clears bit 8 first
// R13 - master remote sleep on energy loss
// R14 - slave remote sleep when master quiet
// R15 - sleep completes only via supply inhibit
// R16 - wake pin high exits sleep
// R17 - partner sends send-s 1.25ms minimum
// R18 - partner sends send-t 1.25ms minimum
// R19 - partner held managed keeps slave asleep
// R20 - same-type partner send-t register steps
// R21 - any compliant master wakes slave
// R22 - reset bit 15 restarts all registers
// R23 - one state; undefined commands ignored
`timescale 1ns/10ps
module posc_ctrl
   import posc_pkg::*;
#(
   parameter int unsigned WAKE_CYC = WAKE_SEQ_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_por_done,
   input wire logic i_strap_autonomous,
   input wire logic i_strap_master,
   input wire logic i_mgmt_wr,
   input wire logic i_mgmt_rd,
   input wire logic [15:0] i_mgmt_addr,
   input wire logic [15:0] i_mgmt_wdata,
   input wire logic i_wake,
   input wire logic i_energy_detect,
   input wire logic i_link_up,
   input wire logic i_wake_pattern,
   input wire logic i_supply_on,
   output logic [15:0] o_mgmt_rdata,
   output logic o_mgmt_rvalid,
   output logic o_pcs_pma_en,
   output logic o_mgmt_active,
   output logic o_supply_inhibit_out,
   output logic o_regs_reset,
   output logic [2:0] o_state
);
   posc_state_e state_q, state_d;
   logic [15:0] pwr_q, pwr_d;
   logic [15:0] cmd_q, cmd_d;
   logic seq_a_q, seq_a_d, seq_b_q, seq_b_d;
   logic strap_auto_q, strap_auto_d, strap_mst_q, strap_mst_d;
   logic latch_q, latch_d;
   logic [2:0] hold_q, hold_d;
   logic inh_q, inh_d;
   logic pcs_q, pcs_d, mgmt_q, mgmt_d, clr_q, clr_d;
   logic [15:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic wake_ok;
   logic acc;
   logic autonomous;
   logic sleep_armed;

   if (WAKE_CYC < 1) begin : g_bad_wake_cyc
      $error("wake qualify count must be positive");
   end

   posc_wake_timer #(.CYCLES(WAKE_CYC)) u_wake (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_pattern(i_wake_pattern),
      .o_qualified(wake_ok)
   );

   // management is only served in standby and normal
   assign acc = (state_q == ST_STANDBY) || (state_q == ST_NORMAL); // [R4] [R9]
   assign autonomous = strap_auto_q | pwr_q[BIT_AUTONOMOUS]; // [R7]
   assign sleep_armed = pwr_q[BIT_SLEEP_EN] & seq_a_q & seq_b_q; // [R11] [R12]

   always_comb begin
      state_d = state_q;
      pwr_d = pwr_q;
      cmd_d = cmd_q;
      seq_a_d = seq_a_q;
      seq_b_d = seq_b_q;
      strap_auto_d = strap_auto_q;
      strap_mst_d = strap_mst_q;
      latch_d = 1'b0;
      hold_d = hold_q;
      inh_d = 1'b0;
      rdata_d = rdata_q;
      rvalid_d = 1'b0;
      case (state_q)
         ST_POWER_DOWN: begin
            if (i_por_done) begin
               state_d = ST_RESET;
               latch_d = 1'b1;
            end
         end
         ST_RESET: begin
            // straps only caught when entered from pin reset
            if (latch_q) begin
               strap_auto_d = i_strap_autonomous; // [R1]
               strap_mst_d = i_strap_master;
            end
            pwr_d = PWR_MODE_RST; // [R10] [R22]
            cmd_d = STATE_CMD_RST;
            seq_a_d = 1'b0;
            seq_b_d = 1'b0;
            if (hold_q != 3'h0) begin
               hold_d = hold_q - 3'h1;
            end else if (strap_auto_d) begin
               // decide on the strap caught this cycle, not the stale latch
               state_d = ST_NORMAL; // [R5]
            end else begin
               state_d = ST_STANDBY; // [R2]
            end
         end
         ST_STANDBY, ST_NORMAL: begin
            if (i_mgmt_rd) begin
               rvalid_d = 1'b1;
               rdata_d = (i_mgmt_addr == ADDR_PWR_MODE) ? pwr_q :
                  (i_mgmt_addr == ADDR_STATE_CMD) ? cmd_q : 16'h0000;
            end
            if (i_mgmt_wr) begin
               if (i_mgmt_addr == ADDR_PWR_MODE) begin
                  pwr_d = i_mgmt_wdata;
               end
               if (i_mgmt_addr == ADDR_SLEEP_A) begin
                  seq_a_d = (i_mgmt_wdata == SLEEP_A_VAL);
               end
               if (i_mgmt_addr == ADDR_SLEEP_B) begin
                  seq_b_d = (i_mgmt_wdata == SLEEP_B_VAL);
               end
               if (i_mgmt_addr == ADDR_STATE_CMD) begin
                  cmd_d = i_mgmt_wdata;
                  // other codes or wrong-state codes are ignored
                  if (state_q == ST_STANDBY && i_mgmt_wdata == CMD_TO_NORMAL) begin
                     state_d = ST_NORMAL; // [R6] [R23]
                  end else if (state_q == ST_NORMAL && i_mgmt_wdata == CMD_TO_STANDBY) begin
                     state_d = ST_STANDBY; // [R8] [R23]
                  end
               end
               if (i_mgmt_addr == ADDR_RESET_CTRL && i_mgmt_wdata[BIT_HW_RESET]) begin
                  state_d = ST_RESET; // [R22]
                  hold_d = 3'(RST_HOLD_CYC);
               end
            end
            if (state_q == ST_STANDBY && autonomous && state_d == ST_STANDBY) begin
               state_d = ST_NORMAL; // [R7]
            end
            if (state_q == ST_NORMAL && !i_wake && pwr_q[BIT_SLEEP_EN]) begin
               // local needs the two sleep writes, remote needs quiet line
               if (sleep_armed && !i_link_up) begin
                  inh_d = 1'b1; // [R11] [R12]
               end else if (!i_energy_detect &&
                  (strap_mst_q ? pwr_q[BIT_REMOTE_SLEEP] : 1'b1)) begin
                  inh_d = 1'b1; // [R13] [R14]
               end
            end
            if (inh_q) begin
               inh_d = 1'b1;
               // only treated as asleep once supplies really drop
               if (!i_supply_on) begin
                  state_d = ST_SLEEP; // [R15]
               end
            end
         end
         ST_SLEEP: begin
            inh_d = 1'b1;
            if (i_wake || wake_ok) begin
               inh_d = 1'b0;
               state_d = ST_RESET; // [R16] [R17] [R18] [R21]
               hold_d = 3'(RST_HOLD_CYC);
            end
         end
         default: begin
            state_d = ST_POWER_DOWN;
         end
      endcase
      pcs_d = (state_d == ST_NORMAL); // [R3]
      mgmt_d = (state_d == ST_STANDBY) || (state_d == ST_NORMAL); // [R4] [R9]
      clr_d = (state_d == ST_RESET); // [R10]
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_q <= ST_POWER_DOWN;
         pwr_q <= PWR_MODE_RST;
         cmd_q <= STATE_CMD_RST;
         seq_a_q <= 1'b0;
         seq_b_q <= 1'b0;
         latch_q <= 1'b0;
         hold_q <= 3'h0;
         inh_q <= 1'b0;
         pcs_q <= 1'b0;
         mgmt_q <= 1'b0;
         clr_q <= 1'b1;
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pwr_q <= pwr_d;
         cmd_q <= cmd_d;
         seq_a_q <= seq_a_d;
         seq_b_q <= seq_b_d;
         latch_q <= latch_d;
         hold_q <= hold_d;
         inh_q <= inh_d;
         pcs_q <= pcs_d;
         mgmt_q <= mgmt_d;
         clr_q <= clr_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // straps survive register reset, so they sit outside the reset branch
   always_ff @(posedge i_core_clk) begin
      strap_auto_q <= strap_auto_d; // [R1]
      strap_mst_q <= strap_mst_d;
   end

   assign o_mgmt_rdata = rdata_q;
   assign o_mgmt_rvalid = rvalid_q;
   assign o_pcs_pma_en = pcs_q;
   assign o_mgmt_active = mgmt_q;
   assign o_supply_inhibit_out = inh_q;
   assign o_regs_reset = clr_q;
   assign o_state = state_q;

   a_standby_no_pcs: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [R3]
      (state_q == ST_STANDBY) |-> !pcs_q)
      else $error("pcs enabled in standby");
   a_sleep_no_mgmt: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [R9]
      (state_q == ST_SLEEP) |-> !mgmt_q && !pcs_q)
      else $error("management active in sleep");
   a_cmd_to_normal: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [R6]
      (state_q == ST_STANDBY && i_mgmt_wr && i_mgmt_addr == ADDR_STATE_CMD && i_mgmt_wdata == CMD_TO_NORMAL)
      |=> state_q == ST_NORMAL && pcs_q)
      else $error("standby did not leave on command");
   a_cmd_to_standby: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [R8]
      (state_q == ST_NORMAL && i_mgmt_wr && i_mgmt_addr == ADDR_STATE_CMD && i_mgmt_wdata == CMD_TO_STANDBY
      && !inh_q && !autonomous) |=> state_q == ST_STANDBY)
      else $error("normal did not return to standby");
   a_sleep_needs_inh: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [R15]
      (state_q != ST_SLEEP) ##1 (state_q == ST_SLEEP) |-> $past(inh_q) && !$past(i_supply_on))
      else $error("sleep without supply cut");
   a_wake_exits: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [R16]
      (state_q == ST_SLEEP && i_wake) |=> state_q == ST_RESET && !inh_q)
      else $error("wake pin ignored");
   a_reset_defaults: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [R10]
      (state_q == ST_RESET) |=> pwr_q == PWR_MODE_RST)
      else $error("registers kept across reset");
   a_managed_standby: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [R2]
      (state_q == ST_RESET && hold_q == 3'h0 && !(latch_q ? i_strap_autonomous : strap_auto_q))
      |=> state_q == ST_STANDBY)
      else $error("managed reset did not reach standby");
   a_auto_normal: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [R5]
      (state_q == ST_RESET && hold_q == 3'h0 && (latch_q ? i_strap_autonomous : strap_auto_q))
      |=> state_q == ST_NORMAL)
      else $error("autonomous reset did not reach normal");
   a_strap_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [R1]
      (state_q == ST_RESET && !latch_q) |=> $stable(strap_auto_q))
      else $error("straps changed on register reset");
endmodule // posc_ctrl

// File: test/posc_link_partner.sv
// Purpose: link partner on the pair plus the switched supply of the device
// Assumes: wake patterns are whole core-clock cycles long
// Notes: supply follows the inhibit output one cycle late unless held on
`timescale 1ns/10ps
module posc_link_partner (
   input wire logic i_core_clk,
   input wire logic i_inhibit,
   input wire logic i_keep_supply,
   output logic o_energy,
   output logic o_pattern,
   output logic o_supply_on
);
   initial begin
      o_energy = 1'b1;
      o_pattern = 1'b0;
      o_supply_on = 1'b1;
   end
   // a stuck regulator is modelled by keep_supply, so sleep must not complete
   always @(posedge i_core_clk) o_supply_on <= i_keep_supply | ~i_inhibit;
   // partner held in managed mode: no data, no wake pattern
   task automatic quiet();
      @(posedge i_core_clk);
      #2;
      o_energy = 1'b0;
      o_pattern = 1'b0;
   endtask
   // send-s or send-t for n cycles, then the pattern drops with energy left on
   task automatic wake_seq(input int n);
      @(posedge i_core_clk);
      #2;
      o_energy = 1'b1;
      o_pattern = 1'b1;
      repeat (n) @(posedge i_core_clk);
      #2;
      o_pattern = 1'b0;
   endtask
endmodule // posc_link_partner

// File: test/phy_operating_state_control_tb.sv
// Purpose: self-checking bench for the operating state controller
// Assumes: slave-role managed straps until the second pin reset, master autonomous after it; wake qualification shortened to 8 cycles
// Notes: inputs change 2 ns after the rising edge
`timescale 1ns/10ps
module phy_operating_state_control_tb;
   import posc_pkg::*;
   localparam int unsigned WCYC = 8;
   logic clk, rst_n, por, s_auto, mst, wr, rd, wake, keep, rvalid, pcs, act, supply_inhibit_out, rrst, energy, pat, sup;
   logic [15:0] addr, wdata, rdata;
   logic [2:0] st;
   int err_count, total_checks, cyc;
   posc_ctrl #(.WAKE_CYC(WCYC)) u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_por_done(por),
      .i_strap_autonomous(s_auto), .i_strap_master(mst), .i_mgmt_wr(wr), .i_mgmt_rd(rd),
      .i_mgmt_addr(addr), .i_mgmt_wdata(wdata), .i_wake(wake), .i_energy_detect(energy),
      .i_link_up(1'b0), .i_wake_pattern(pat), .i_supply_on(sup), .o_mgmt_rdata(rdata),
      .o_mgmt_rvalid(rvalid), .o_pcs_pma_en(pcs), .o_mgmt_active(act),
      .o_supply_inhibit_out(supply_inhibit_out), .o_regs_reset(rrst), .o_state(st));
   posc_link_partner u_lp (.i_core_clk(clk), .i_inhibit(supply_inhibit_out), .i_keep_supply(keep),
      .o_energy(energy), .o_pattern(pat), .o_supply_on(sup));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic test_done();
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // whole run needs well under 300 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         test_done();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic wrt(input logic [15:0] a, input logic [15:0] d);
      step(1);
      wr = 1'b1;
      addr = a;
      wdata = d;
      step(1);
      wr = 1'b0;
   endtask
   // the answer stands only in the cycle after the strobe edge
   task automatic rdc(input logic [15:0] a, input logic [15:0] exp, input logic ok);
      step(1);
      rd = 1'b1;
      addr = a;
      step(1);
      rd = 1'b0;
      chk(16'(rvalid), 16'(ok), "read answer");
      if (ok) chk(rdata, exp, "read data");
   endtask
   task automatic cst(input posc_state_e e);
      chk(16'(st), 16'(e), "state");
   endtask
   initial begin
      rst_n = 1'b0;
      por = 1'b0;
      s_auto = 1'b0;
      mst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 16'h0000;
      wdata = 16'h0000;
      wake = 1'b1;
      keep = 1'b0;
      err_count = 0;
      total_checks = 0;
      cyc = 0;
      step(10);
      rst_n = 1'b1;
      step(3);
      cst(ST_POWER_DOWN);
      por = 1'b1;
      step(4);
      cst(ST_STANDBY);
      chk(16'(pcs), 16'h0000, "pcs in standby");
      chk(16'(act), 16'h0001, "mgmt in standby");
      rdc(ADDR_PWR_MODE, PWR_MODE_RST, 1'b1);
      rdc(16'h0123, 16'h0000, 1'b1);
      wrt(ADDR_STATE_CMD, CMD_TO_STANDBY);
      step(2);
      cst(ST_STANDBY);
      wrt(ADDR_STATE_CMD, CMD_TO_NORMAL);
      step(2);
      cst(ST_NORMAL);
      chk(16'(pcs), 16'h0001, "pcs in normal");
      rdc(ADDR_STATE_CMD, CMD_TO_NORMAL, 1'b1);
      wrt(ADDR_STATE_CMD, CMD_TO_STANDBY);
      step(2);
      cst(ST_STANDBY);
      wrt(ADDR_PWR_MODE, 16'h0040);
      step(2);
      cst(ST_NORMAL);
      // local sleep, slave role, regulator first refusing to switch off
      wrt(ADDR_PWR_MODE, 16'h0040);
      wrt(ADDR_PWR_MODE, 16'h00c0);
      wrt(ADDR_SLEEP_A, SLEEP_A_VAL);
      wrt(ADDR_SLEEP_B, SLEEP_B_VAL);
      keep = 1'b1;
      wake = 1'b0;
      step(6);
      chk(16'(supply_inhibit_out), 16'h0001, "inhibit");
      cst(ST_NORMAL);
      keep = 1'b0;
      step(4);
      cst(ST_SLEEP);
      chk({14'h0, pcs, act}, 16'h0000, "sleep outputs");
      rdc(ADDR_PWR_MODE, 16'h0000, 1'b0);
      wake = 1'b1;
      step(10);
      cst(ST_STANDBY);
      rdc(ADDR_PWR_MODE, PWR_MODE_RST, 1'b1);
      // remote sleep as slave, then wake by pattern
      wrt(ADDR_STATE_CMD, CMD_TO_NORMAL);
      wrt(ADDR_PWR_MODE, 16'h0080);
      wake = 1'b0;
      u_lp.quiet();
      step(6);
      cst(ST_SLEEP);
      u_lp.wake_seq(WCYC - 2);
      step(4);
      cst(ST_SLEEP);
      u_lp.wake_seq(WCYC + 4);
      step(8);
      cst(ST_STANDBY);
      // register reset keeps the latched managed strap
      s_auto = 1'b1;
      mst = 1'b1;
      wrt(ADDR_RESET_CTRL, 16'h8000);
      step(1);
      cst(ST_RESET);
      chk(16'(rrst), 16'h0001, "regs reset");
      step(8);
      cst(ST_STANDBY);
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      step(8);
      cst(ST_NORMAL);
      chk(16'(pcs), 16'h0001, "autonomous pcs");
      // remote sleep as master: needs bit 8 as well as bit 7
      wrt(ADDR_PWR_MODE, 16'h0080);
      wake = 1'b0;
      u_lp.quiet();
      step(6);
      cst(ST_NORMAL);
      chk(16'(supply_inhibit_out), 16'h0000, "master inhibit without bit 8");
      wrt(ADDR_PWR_MODE, 16'h0180);
      step(6);
      cst(ST_SLEEP);
      wake = 1'b1;
      step(10);
      cst(ST_NORMAL);
      rdc(ADDR_PWR_MODE, PWR_MODE_RST, 1'b1);
      test_done();
   end
endmodule // phy_operating_state_control_tb
